// File: pkg/pwc_pkg.sv
// pwm wave counter package: register map, field layout, modes and carriers
// assumes a classic wishbone slave with 32-bit data and byte addresses
package pwc_pkg;

  localparam int PWC_CNT_W = 15;
  localparam int PWC_NUM_CH = 4;
  localparam int PWC_WAVE_CH = 3;
  localparam int PWC_PRE_W = 3;

  // register byte offsets
  localparam logic [7:0] PWC_OFS_ENABLE = 8'h00;
  localparam logic [7:0] PWC_OFS_MODE = 8'h04;
  localparam logic [7:0] PWC_OFS_PRESCALE = 8'h08;
  localparam logic [7:0] PWC_OFS_TOP = 8'h0C;
  localparam logic [7:0] PWC_OFS_LAYOUT = 8'h10;
  localparam logic [7:0] PWC_OFS_STATUS = 8'h14;
  localparam logic [7:0] PWC_OFS_COUNT = 8'h18;

  // reset values
  localparam logic [14:0] PWC_TOP_RST = 15'h03E8;
  localparam logic [2:0] PWC_PRE_RST = 3'h0;

  // parameter half-word and status register layout
  localparam int PWC_POL_BIT = 15;
  localparam int PWC_STATUS_RUN_BIT = 0;
  localparam int PWC_STATUS_DIR_BIT = 1;
  localparam int PWC_STATUS_OUT_LSB = 4;

  localparam logic [31:0] PWC_RD_ZERO = 32'h0000_0000;

  typedef enum logic {
    PWC_COUNT_UP,
    PWC_COUNT_UP_DOWN
  } pwc_mode_t;

  // one loaded parameter half-word
  typedef struct packed {
    logic first_edge_falling;
    logic [14:0] compare;
  } pwc_param_t;

  // compare-load request from the memory-fed decoder
  typedef struct packed {
    logic load;
    logic [3:0] ch_mask;
    pwc_param_t [3:0] param;
    logic top_valid;
    logic [14:0] top;
  } pwc_load_t;

endpackage

// File: hw/pwc_tick_div.sv
// pwm tick divider: one-cycle enable every 2**sel system clocks
// assumes clk_sys domain; sel is stable or changes only between ticks
`timescale 1ns/100ps
module pwc_tick_div
  import pwc_pkg::*;
#(
  parameter int SEL_W = PWC_PRE_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // control
  input wire logic run,
  input wire logic [SEL_W-1:0] sel,
  // tick out
  output logic tick
);

  localparam int DIV_W = 1 << SEL_W;

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] low_mask;

  // free counter, cleared while stopped so the first period is whole
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
    end else if (!run || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // tick when the low sel bits are all ones
  always_comb begin
    low_mask = DIV_W'((1 << sel) - 1);
    tick = run && (&(div_reg | ~low_mask));
  end

endmodule

// File: hw/pwc_channel.sv
// one compare channel: turns counter and compare value into an output level
// assumes top and compare are updated only at period boundaries, the counter on each tick
`timescale 1ns/100ps
module pwc_channel
  import pwc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // shared counter state
  input wire logic run,
  input wire logic [PWC_CNT_W-1:0] count,
  input wire logic [PWC_CNT_W-1:0] top,
  // channel setting
  input wire pwc_param_t param,
  // pin
  output logic out
);

  logic level_next;
  logic out_reg;

  // falling-first form: high below compare, low from compare on
  always_comb begin
    if (param.compare == '0) begin
      level_next = 1'b0;
    end else if (top < param.compare || param.compare == top) begin
      level_next = 1'b1;
    end else begin
      level_next = (count < param.compare);
    end
    level_next = param.first_edge_falling ? level_next : ~level_next;
  end

  // registered output; idle low while stopped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= run ? level_next : 1'b0;
    end
  end

  assign out = out_reg;

endmodule

// File: hw/pwc_wave_counter.sv
// pwm wave counter top: shared 15-bit counter, four compare channels, wishbone regs
// assumes a decoder delivers compare loads at period ends and a launch pulse
//
// Behaviour
// - one shared 15-bit counter feeds four compare channels
// - per-channel duty and polarity, common period for all channels
// - polarity comes from the loaded parameter word, not software register
// - software mode bit selects up-only or up-then-down counting
// - top value register is the turnaround limit, with the tick divider
// - top below compare gives no edges; falling-first output held high
// - compare registers internal, loaded only from the decoder path
// - top value register writable any time without corrupting output
// - wave layout uses top delivered from memory when top_valid is set, else the software top
// - otherwise top is sampled at launch and at each parameter load
// - up-only: counter clears at top, outputs restart the period
// - falling-first: compare zero holds low, compare equal top holds high
// - up-only pulses are edge-aligned at period start
// - up-only period is tick period times top value
// - up-down: decrement from top, second match toggles, centre aligned
// - up-down period is two tick periods times top value
// - new duty values apply autonomously and glitch-free
// - polarity, duty and period may change once per period
// - parameter bit 15 is polarity, bits 14:0 are compare value
// - polarity zero gives rising first edge, one gives falling first
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module pwc_wave_counter
  import pwc_pkg::*;
#(
  parameter int NUM_CH = PWC_NUM_CH,
  parameter logic [PWC_CNT_W-1:0] TOP_RESET = PWC_TOP_RST
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // decoder side
  input wire logic sequence_launch_task,
  input wire pwc_load_t load_i,
  output logic period_end,
  // pins
  output logic [NUM_CH-1:0] pwm_out
);

  // register state
  logic enable_reg;
  pwc_mode_t mode_reg;
  logic [PWC_PRE_W-1:0] prescale_reg;
  logic [PWC_CNT_W-1:0] period_top_value_reg;
  logic arbitrary_wave_layout_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // counter state
  logic [PWC_CNT_W-1:0] count_reg;
  logic [PWC_CNT_W-1:0] top_act_reg;
  logic down_reg;
  logic run_reg;
  pwc_param_t [NUM_CH-1:0] cmp_reg;
  pwc_param_t [NUM_CH-1:0] cmp_next;
  logic pend_reg;
  logic [NUM_CH-1:0] pend_mask_reg;
  pwc_param_t [NUM_CH-1:0] pend_param_reg;
  logic [PWC_CNT_W-1:0] pend_top_reg;

  logic tick;
  logic wrap;
  logic bus_req;
  logic bus_wr;
  logic bus_rd;
  logic [15:0] top_merge;

  // address match, used only by the write decoding
  function automatic logic adr_is(input logic [7:0] a, input logic [7:0] ofs);
    adr_is = (a == ofs);
  endfunction

  // byte lanes steering a register of up to 16 bits
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign bus_wr = bus_req && wb_we_i;
  assign bus_rd = bus_req && !wb_we_i;

  // byte lanes applied to the top register ahead of the write
  assign top_merge = lane_merge({1'b0, period_top_value_reg}, wb_dat_i, wb_sel_i);

  // one-wait-state ack, dropped the cycle after; unmapped reads give zero
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  // software-writable control; compare registers have no address at all
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= 1'b0;
      mode_reg <= PWC_COUNT_UP;
      prescale_reg <= PWC_PRE_RST;
      period_top_value_reg <= TOP_RESET;
      arbitrary_wave_layout_reg <= 1'b0;
    end else if (bus_wr) begin
      if (adr_is(wb_adr_i, PWC_OFS_ENABLE) && wb_sel_i[0]) begin
        enable_reg <= wb_dat_i[0];
      end
      if (adr_is(wb_adr_i, PWC_OFS_MODE) && wb_sel_i[0]) begin
        mode_reg <= wb_dat_i[0] ? PWC_COUNT_UP_DOWN : PWC_COUNT_UP;
      end
      if (adr_is(wb_adr_i, PWC_OFS_PRESCALE) && wb_sel_i[0]) begin
        prescale_reg <= wb_dat_i[PWC_PRE_W-1:0];
      end
      if (adr_is(wb_adr_i, PWC_OFS_TOP)) begin
        // shadow only; the counter never sees it mid-period
        period_top_value_reg <= top_merge[PWC_CNT_W-1:0];
      end
      if (adr_is(wb_adr_i, PWC_OFS_LAYOUT) && wb_sel_i[0]) begin
        arbitrary_wave_layout_reg <= wb_dat_i[0];
      end
    end
  end

  // read mux, captured so data comes from flip-flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= PWC_RD_ZERO;
    end else if (bus_rd) begin
      rdata_reg <= PWC_RD_ZERO;
      case (wb_adr_i)
        PWC_OFS_ENABLE: rdata_reg[0] <= enable_reg;
        PWC_OFS_MODE: rdata_reg[0] <= (mode_reg == PWC_COUNT_UP_DOWN);
        PWC_OFS_PRESCALE: rdata_reg[PWC_PRE_W-1:0] <= prescale_reg;
        PWC_OFS_TOP: rdata_reg[PWC_CNT_W-1:0] <= period_top_value_reg;
        PWC_OFS_LAYOUT: rdata_reg[0] <= arbitrary_wave_layout_reg;
        PWC_OFS_STATUS: begin
          rdata_reg[PWC_STATUS_RUN_BIT] <= run_reg;
          rdata_reg[PWC_STATUS_DIR_BIT] <= down_reg;
          rdata_reg[PWC_STATUS_OUT_LSB +: NUM_CH] <= pwm_out;
        end
        PWC_OFS_COUNT: rdata_reg[PWC_CNT_W-1:0] <= count_reg;
        default: rdata_reg <= PWC_RD_ZERO;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // shared tick divider sets the step width for every channel
  pwc_tick_div #(
    .SEL_W(PWC_PRE_W)
  ) u_pwc_tick_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .run(run_reg),
    .sel(prescale_reg),
    .tick(tick)
  );

  // run starts at a launch once enabled, stops when disabled
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_reg <= 1'b0;
    end else if (!enable_reg) begin
      run_reg <= 1'b0;
    end else if (sequence_launch_task) begin
      run_reg <= 1'b1;
    end
  end

  // period end: up-only wraps at top, up-down turns back at zero
  always_comb begin
    if (mode_reg == PWC_COUNT_UP) begin
      wrap = tick && (count_reg >= top_act_reg - 1'b1);
    end else begin
      wrap = tick && down_reg && (count_reg <= 15'h0001);
    end
  end
  assign period_end = wrap;

  // the single shared counter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      down_reg <= 1'b0;
    end else if (!run_reg || sequence_launch_task) begin
      count_reg <= '0;
      down_reg <= 1'b0;
    end else if (tick) begin
      if (mode_reg == PWC_COUNT_UP) begin
        down_reg <= 1'b0;
        count_reg <= wrap ? '0 : count_reg + 1'b1;
      end else if (!down_reg) begin
        if (count_reg + 1'b1 >= top_act_reg) begin
          down_reg <= 1'b1;
        end
        count_reg <= count_reg + 1'b1;
      end else if (wrap) begin
        down_reg <= 1'b0;
        count_reg <= '0;
      end else begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // decoder loads are held pending and applied only at a period end or a launch
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= 1'b0;
      pend_mask_reg <= '0;
      pend_param_reg <= '0;
      pend_top_reg <= TOP_RESET;
    end else if (load_i.load) begin
      pend_reg <= 1'b1;
      pend_mask_reg <= load_i.ch_mask[NUM_CH-1:0];
      pend_param_reg <= load_i.param[NUM_CH-1:0];
      // wave layout takes the top that came with the parameters
      pend_top_reg <= (arbitrary_wave_layout_reg && load_i.top_valid) ? load_i.top : period_top_value_reg;
    end else if (wrap || sequence_launch_task) begin
      pend_reg <= 1'b0;
    end
  end

  // compare and top take effect together when a load is pending, once per period at most; a launch with none pending reloads only top, outside wave layout
  always_comb begin
    cmp_next = cmp_reg;
    for (int i = 0; i < NUM_CH; i++) begin
      if (pend_mask_reg[i]) begin
        cmp_next[i] = pend_param_reg[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmp_reg <= '0;
      top_act_reg <= TOP_RESET;
    end else if (pend_reg && (wrap || sequence_launch_task)) begin
      cmp_reg <= cmp_next;
      top_act_reg <= pend_top_reg;
    end else if (sequence_launch_task && !arbitrary_wave_layout_reg) begin
      top_act_reg <= period_top_value_reg;
    end
  end

  // channels, all reading the one counter and one active top
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      pwc_channel u_pwc_channel (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .run(run_reg),
        .count(count_reg),
        .top(top_act_reg),
        .param(cmp_reg[g]),
        .out(pwm_out[g])
      );
    end
  endgenerate

  // checks on the bus handshake and the shared counter
  chk_ack_one_cycle: assert property (@(posedge clk_sys) disable iff (!rstn)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_count_below_top: assert property (@(posedge clk_sys) disable iff (!rstn)
    (run_reg && top_act_reg != '0) |-> count_reg <= top_act_reg)
    else $error("counter past top");
  chk_up_wraps_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrap && mode_reg == PWC_COUNT_UP && !sequence_launch_task) |=> count_reg == '0)
    else $error("no wrap");
  chk_up_no_down: assert property (@(posedge clk_sys) disable iff (!rstn)
    (run_reg && tick && mode_reg == PWC_COUNT_UP) |=> !down_reg)
    else $error("down in up");
  chk_updown_turn: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tick && run_reg && !down_reg && mode_reg == PWC_COUNT_UP_DOWN && !sequence_launch_task
     && count_reg + 1'b1 >= top_act_reg) |=> down_reg)
    else $error("no turnaround");
  chk_updown_bottom: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wrap && mode_reg == PWC_COUNT_UP_DOWN && !sequence_launch_task) |=> (count_reg == '0 && !down_reg))
    else $error("no return to zero");
  chk_count_holds: assert property (@(posedge clk_sys) disable iff (!rstn)
    (run_reg && !tick && !sequence_launch_task) |=> $stable(count_reg))
    else $error("counter moved without tick");

  // loads and the top value reach the counter only at period boundaries; pins idle low while stopped
  chk_load_pending: assert property (@(posedge clk_sys) disable iff (!rstn)
    load_i.load |=> pend_reg)
    else $error("load not held pending");
  chk_wave_top_load: assert property (@(posedge clk_sys) disable iff (!rstn)
    (load_i.load && arbitrary_wave_layout_reg && load_i.top_valid) |=> pend_top_reg == $past(load_i.top))
    else $error("wave top not taken");
  chk_load_top_sample: assert property (@(posedge clk_sys) disable iff (!rstn)
    (load_i.load && !arbitrary_wave_layout_reg) |=> pend_top_reg == $past(period_top_value_reg))
    else $error("top not sampled at load");
  chk_launch_top_sample: assert property (@(posedge clk_sys) disable iff (!rstn)
    (sequence_launch_task && !pend_reg && !arbitrary_wave_layout_reg) |=> top_act_reg == $past(period_top_value_reg))
    else $error("top not sampled at launch");
  chk_cmp_only_at_end: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(cmp_reg) |-> $past(wrap) || $past(sequence_launch_task))
    else $error("compare changed mid-period");
  chk_top_only_at_end: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(top_act_reg) |-> $past(wrap) || $past(sequence_launch_task))
    else $error("top changed mid-period");
  chk_stopped_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
    !run_reg |=> pwm_out == '0)
    else $error("outputs not idle");

  // per-channel pin levels; a pin shows the compare state one cycle later
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chk
      chk_zero_holds_low: assert property (@(posedge clk_sys) disable iff (!rstn)
        (run_reg && cmp_reg[g].compare == '0) |=> pwm_out[g] == !$past(cmp_reg[g].first_edge_falling))
        else $error("zero compare level wrong");
      chk_full_holds_high: assert property (@(posedge clk_sys) disable iff (!rstn)
        (run_reg && cmp_reg[g].compare != '0 && top_act_reg <= cmp_reg[g].compare)
        |=> pwm_out[g] == $past(cmp_reg[g].first_edge_falling))
        else $error("full compare level wrong");
    end
  endgenerate

  // main scenarios worth seeing at least once
  cov_up_wrap: cover property (@(posedge clk_sys) disable iff (!rstn)
    wrap && mode_reg == PWC_COUNT_UP);
  cov_updown_wrap: cover property (@(posedge clk_sys) disable iff (!rstn)
    wrap && mode_reg == PWC_COUNT_UP_DOWN);
  cov_wave_load: cover property (@(posedge clk_sys) disable iff (!rstn)
    load_i.load && arbitrary_wave_layout_reg && load_i.top_valid);
  cov_relaunch: cover property (@(posedge clk_sys) disable iff (!rstn)
    sequence_launch_task && run_reg);
  cov_prescaled_hold: cover property (@(posedge clk_sys) disable iff (!rstn)
    run_reg && !tick);

endmodule

// File: bench/pwc_pin_load.sv
// pin load model: senses the four pwm pins as external loads would
// assumes period_end marks the last system cycle of each pwm period
`timescale 1ns/100ps
module pwc_pin_load
  import pwc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // sensed signals
  input wire logic [3:0] pins,
  input wire logic period_end,
  // measurements of the last whole period
  output logic [15:0] per_len,
  output logic [3:0][15:0] hi_cnt,
  output int periods
);
  logic [15:0] len_acc;
  logic [3:0][15:0] hi_acc;

  // high time per pin and period length; a lag of the pins shifts the window but not the totals
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      len_acc <= '0;
      hi_acc <= '0;
      per_len <= '0;
      hi_cnt <= '0;
      periods <= 0;
    end else if (period_end) begin
      per_len <= len_acc + 16'h0001;
      len_acc <= '0;
      for (int i = 0; i < 4; i++) begin
        hi_cnt[i] <= hi_acc[i] + 16'(pins[i]);
        hi_acc[i] <= '0;
      end
      periods <= periods + 1;
    end else begin
      len_acc <= len_acc + 16'h0001;
      for (int i = 0; i < 4; i++) begin
        hi_acc[i] <= hi_acc[i] + 16'(pins[i]);
      end
    end
  end
endmodule

// File: bench/tb_pwc_wave_counter.sv
// testbench for the pwm wave counter: wishbone set-up, decoder loads, pin measurement
// assumes prescale 0 gives one tick per system clock and loads apply at period end or launch
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module tb_pwc_wave_counter;
  import pwc_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic launch = 1'b0;
  pwc_load_t load_i = '0;
  logic period_end;
  logic [3:0] pwm_out;
  logic [15:0] per_len;
  logic [3:0][15:0] hi_cnt;
  int periods;
  int num_errors = 0;
  int checks_done = 0;
  logic [31:0] rd;

  pwc_wave_counter u_pwc_wave_counter (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .sequence_launch_task(launch), .load_i(load_i), .period_end(period_end),
    .pwm_out(pwm_out));
  pwc_pin_load u_pwc_pin_load (.clk_sys(clk_sys), .rstn(rstn), .pins(pwm_out), .period_end(period_end),
    .per_len(per_len), .hi_cnt(hi_cnt), .periods(periods));

  // 20 mhz system clock
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    num_errors++;
    $display("mismatch %s expected done seen timeout", what);
    test_done();
  endtask

  // one classic cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    if (wb_ack !== 1'b1) timed_out("wishbone ack");
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask

  function automatic logic [15:0] pp(input logic fall, input logic [14:0] cmp);
    return {fall, cmp};
  endfunction

  // decoder load pulse; param[0] sits in the low half-word
  task automatic do_load(input logic [63:0] prm, input logic tv, input logic [14:0] tp);
    @(posedge clk_sys);
    load_i <= {1'b1, 4'hF, prm, tv, tp};
    @(posedge clk_sys);
    load_i.load <= 1'b0;
  endtask

  task automatic do_launch();
    @(posedge clk_sys);
    launch <= 1'b1;
    @(posedge clk_sys);
    launch <= 1'b0;
  endtask

  task automatic wait_periods(input int n);
    int start;
    int k;
    start = periods;
    k = 0;
    while (periods < start + n && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 4000) timed_out("period end");
  endtask

  task automatic chk_per(input int len, input int h0, input int h1, input int h2, input int h3);
    `CHK("period length", 16'(len), per_len)
    `CHK("ch0 high", 16'(h0), hi_cnt[0])
    `CHK("ch1 high", 16'(h1), hi_cnt[1])
    `CHK("ch2 high", 16'(h2), hi_cnt[2])
    `CHK("ch3 high", 16'(h3), hi_cnt[3])
  endtask

  // reset values, read-only and unmapped places
  task automatic sc_regs();
    wb_xfer(1'b0, PWC_OFS_TOP, '0, rd);
    `CHK("top reset", 32'h0000_03E8, rd)
    wb_xfer(1'b0, PWC_OFS_MODE, '0, rd);
    `CHK("mode reset", 32'h0000_0000, rd)
    wb_wr(8'h1C, 32'hFFFF_FFFF);
    wb_xfer(1'b0, 8'h1C, '0, rd);
    `CHK("unmapped", PWC_RD_ZERO, rd)
    wb_wr(PWC_OFS_STATUS, 32'h0000_00FF);
    wb_xfer(1'b0, PWC_OFS_STATUS, '0, rd);
    `CHK("status idle", 32'h0000_0000, rd)
    `CHK("pins idle", 4'h0, pwm_out)
  endtask

  // up mode: complement pair, zero compare, compare equal top
  task automatic sc_up();
    wb_wr(PWC_OFS_ENABLE, 32'h0000_0001);
    wb_wr(PWC_OFS_TOP, 32'h0000_0014);
    do_load({pp(1, 20), pp(1, 0), pp(0, 5), pp(1, 5)}, 1'b0, 15'h0000);
    do_launch();
    wait_periods(3);
    chk_per(20, 5, 15, 0, 20);
    wb_xfer(1'b0, PWC_OFS_COUNT, '0, rd);
    `CHK("count below top", 1'b1, rd < 32'h0000_0014)
    wb_xfer(1'b0, PWC_OFS_STATUS, '0, rd);
    `CHK("status run up", 2'b01, rd[1:0])
  endtask

  // update while running, compare above top
  task automatic sc_update();
    do_load({pp(1, 30), pp(0, 30), pp(1, 7), pp(0, 0)}, 1'b0, 15'h0000);
    wait_periods(3);
    chk_per(20, 20, 7, 0, 20);
  endtask

  // top written mid-run only takes hold at the next load
  task automatic sc_top();
    wb_wr(PWC_OFS_TOP, 32'h0000_000A);
    wait_periods(2);
    chk_per(20, 20, 7, 0, 20);
    do_load({pp(1, 10), pp(1, 0), pp(0, 4), pp(1, 4)}, 1'b0, 15'h0000);
    wait_periods(3);
    chk_per(10, 4, 6, 0, 10);
  endtask

  // up-down: twice the ticks, complement pair fills the period
  task automatic sc_updown();
    wb_wr(PWC_OFS_MODE, 32'h0000_0001);
    do_launch();
    wait_periods(3);
    `CHK("updown length", 16'd20, per_len)
    `CHK("updown pair", 16'd20, 16'(hi_cnt[0] + hi_cnt[1]))
    `CHK("updown zero", 16'd0, hi_cnt[2])
    `CHK("updown full", 16'd20, hi_cnt[3])
  endtask

  // wave layout takes top from the load, not the register
  task automatic sc_wave();
    wb_wr(PWC_OFS_MODE, 32'h0000_0000);
    wb_wr(PWC_OFS_LAYOUT, 32'h0000_0001);
    wb_wr(PWC_OFS_TOP, 32'h0000_0014);
    do_load({pp(1, 12), pp(1, 0), pp(0, 3), pp(1, 3)}, 1'b1, 15'h000C);
    do_launch();
    wait_periods(3);
    chk_per(12, 3, 9, 0, 12);
  endtask

  // divide-by-two tick doubles the period
  task automatic sc_prescale();
    wb_wr(PWC_OFS_LAYOUT, 32'h0000_0000);
    wb_wr(PWC_OFS_PRESCALE, 32'h0000_0001);
    do_load({pp(1, 20), pp(1, 0), pp(0, 5), pp(1, 5)}, 1'b0, 15'h0000);
    do_launch();
    wait_periods(3);
    chk_per(40, 10, 30, 0, 40);
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    sc_regs();
    sc_up();
    sc_update();
    sc_top();
    sc_updown();
    sc_wave();
    sc_prescale();
    test_done();
  end
endmodule
